// File: design/rvgt_top.sv
// Stereo small reverb followed by a side-chain gate and output level
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
// Overview of operation
// - Side-chain from left, right, or summed amplitudes
// - Gate opens when amplitude exceeds threshold
// - Stays open while above, then hold interval
// - Hold timer reloads whenever above threshold
// - Ducking inverts the gate open state
// - Attack ramp after rising above threshold
// - Release ramp after hold timer elapses
// - Gated path delayed, side-chain undelayed
// - Output level after gate, or off
// - Wet/dry mix; gate works when dry
// - Size multiplier scales room length
// - Density multiplier scales density tap position (chamber and larger rooms only)
// - Room select changes reverb topology
// - Gate applied to reverb output
// - Infinite decay sustains the tail
module rvgt_top import rvgt_pkg::*; (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic        [3:0]  addr_i,
  input  wire logic        [15:0] wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic             [15:0] rdata_o,
  input  wire logic signed [15:0] in_left_i,
  input  wire logic signed [15:0] in_right_i,
  output logic                    sample_req_o,
  output logic signed      [15:0] out_left_o,
  output logic signed      [15:0] out_right_o,
  output logic                    out_valid_o
);
  logic [15:0] ctrl, thresh, hold_ms, atk_t, rel_ms, dly_t, ogain, mix, size_q, dens, decay;
  rvgt_state_type state;
  logic [8:0]  div_cnt;
  logic        tick;
  logic [12:0] clr_cnt;
  logic [16:0] env;
  logic [16:0] sc_amp;
  logic [16:0] next_env;
  logic        next_above;
  logic        above;
  logic [17:0] hold_cnt;
  logic        active;
  logic [17:0] hold_n, atk_n, rel_n;
  logic [10:0] dly_n;
  logic [12:0] rev_wp, rev_len, rev_dlen;
  logic [10:0] dly_wp;
  logic [19:0] len_prod;
  logic [21:0] dlen_prod;
  logic signed [15:0] dry_l, dry_r, tap_l, tap_r, rev_l, rev_r;
  logic signed [15:0] wet_l, wet_r, next_wet_l, next_wet_r;
  logic signed [15:0] gated_l, gated_r;
  logic [15:0] fb;
  logic        duck, inf, out_off;
  rvgt_room_type room;
  logic        rev_we, dly_we;
  logic [12:0] rev_waddr, rev_raddr;
  logic [10:0] dly_waddr, dly_raddr;
  logic [31:0] rev_wdata, rev_rdata, dly_wdata, dly_rdata;
  rvgt_ramp_if rif ();

  function automatic logic [15:0] clampw(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction : clampw

  function automatic logic [16:0] absv(input logic signed [15:0] s);
    return s[15] ? 17'(-$signed({s[15], s})) : {1'b0, s};
  endfunction : absv

  function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
    if (v > 36'sd32767) return 16'sh7fff;
    if (v < -36'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction : sat16

  function automatic logic signed [35:0] mulsh(input logic signed [15:0] s,
                                               input logic [16:0] g, input int sh);
    logic signed [35:0] p;
    p = 36'(s) * 36'($signed({1'b0, g}));
    return p >>> sh;
  endfunction : mulsh

  function automatic logic [10:0] room_len(input rvgt_room_type r);
    case (r)
      ROOM_BOOTH:           return 11'h061;
      ROOM_SMALL:           return 11'h0d3;
      ROOM_CHAMBER:         return 11'h1a3;
      ROOM_HALL_PRESET_ONE: return 11'h377;
      ROOM_LARGE:           return 11'h5db;
      default:              return 11'h377;
    endcase
  endfunction : room_len

  // Register writes; time fields saturate at their top of range
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl    <= CTRL_RST;
      thresh  <= THRESH_RST;
      hold_ms <= HOLD_RST;
      atk_t   <= ATK_RST;
      rel_ms  <= REL_RST;
      dly_t   <= DELAY_RST;
      ogain   <= OGAIN_RST;
      mix     <= MIX_RST;
      size_q  <= SIZE_RST;
      dens    <= DENS_RST;
      decay   <= DECAY_RST;
    end else if (wr_i) begin
      case (addr_i)
        REG_CTRL:   ctrl    <= wdata_i;
        REG_THRESH: thresh  <= wdata_i;
        REG_HOLD:   hold_ms <= clampw(wdata_i, HOLD_MAX_MS);
        REG_ATK:    atk_t   <= clampw(wdata_i, ATK_MAX_TENTHS);
        REG_REL:    rel_ms  <= clampw(wdata_i, REL_MAX_MS);
        REG_DELAY:  dly_t   <= clampw(wdata_i, DLY_MAX_TENTHS);
        REG_OGAIN:  ogain   <= wdata_i;
        REG_MIX:    mix     <= clampw(wdata_i, MIX_FULL_WET);
        REG_SIZE:   size_q  <= clampw(wdata_i, SCALE_MAX);
        REG_DENS:   dens    <= clampw(wdata_i, SCALE_MAX);
        REG_DECAY:  decay   <= wdata_i;
        default:    ;
      endcase
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0;
    end else if (rd_i) begin
      case (addr_i)
        REG_CTRL:   rdata_o <= ctrl;
        REG_THRESH: rdata_o <= thresh;
        REG_HOLD:   rdata_o <= hold_ms;
        REG_ATK:    rdata_o <= atk_t;
        REG_REL:    rdata_o <= rel_ms;
        REG_DELAY:  rdata_o <= dly_t;
        REG_OGAIN:  rdata_o <= ogain;
        REG_MIX:    rdata_o <= mix;
        REG_SIZE:   rdata_o <= size_q;
        REG_DENS:   rdata_o <= dens;
        REG_DECAY:  rdata_o <= decay;
        REG_STATUS: rdata_o <= {rif.gain[16:9], 5'h0, active, hold_cnt != 18'h0, above};
        default:    rdata_o <= 16'h0;
      endcase
    end else begin
      rdata_o <= 16'h0;
    end
  end

  assign duck    = ctrl[CTRL_DUCK];
  assign inf     = ctrl[CTRL_INF];
  assign out_off = ctrl[CTRL_OFF];
  assign room    = rvgt_room_type'(ctrl[CTRL_ROOM_LSB +: 3]);
  assign hold_n  = 18'(hold_ms) * 18'(SAMP_PER_MS);
  assign rel_n   = 18'(rel_ms) * 18'(SAMP_PER_MS);
  assign atk_n   = 18'(atk_t) * 18'(SAMP_PER_TENTH);
  assign dly_n   = 11'(dly_t) * 11'(SAMP_PER_TENTH);

  // Sample-rate enable
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt <= 9'h0;
    end else begin
      div_cnt <= (div_cnt == 9'(SAMPLE_DIV - 1)) ? 9'h0 : div_cnt + 9'h1;
    end
  end
  // Ticks during the clearing sweep are dropped
  assign tick         = (div_cnt == 9'(SAMPLE_DIV - 1)) && (state == ST_IDLE);
  assign sample_req_o = tick;

  // Sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state   <= ST_CLR;
      clr_cnt <= 13'h0;
    end else begin
      case (state)
        ST_CLR: begin
          clr_cnt <= clr_cnt + 13'h1;
          if (clr_cnt == 13'h1fff) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (tick) begin
            state <= ST_TAP;
          end
        end
        ST_TAP:  state <= ST_MIX;
        ST_MIX:  state <= ST_RDD;
        ST_RDD:  state <= ST_OUT;
        ST_OUT:  state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Side-chain amplitude from undelayed input
  always_comb begin
    case (rvgt_sc_type'(ctrl[CTRL_SEL_LSB +: 2]))
      SC_LEFT:  sc_amp = absv(in_left_i);
      SC_RIGHT: sc_amp = absv(in_right_i);
      SC_BOTH:  sc_amp = absv(in_left_i) + absv(in_right_i);
      default:  sc_amp = 17'h0;
    endcase
  end

  // Peak follower: instant rise, slow exponential fall
  assign next_env   = (sc_amp > env) ? sc_amp : env - (env >> ENV_SHIFT);
  assign next_above = next_env > {1'b0, thresh};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      env   <= 17'h0;
      above <= 1'b0;
    end else if (tick) begin
      env   <= next_env;
      above <= next_above;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_cnt <= 18'h0;
    end else if (tick) begin
      if (next_above) begin
        hold_cnt <= hold_n;
      end else if (hold_cnt != 18'h0) begin
        hold_cnt <= hold_cnt - 18'h1;
      end
    end
  end

  assign active    = above || (hold_cnt != 18'h0);
  assign rif.tick  = tick;
  assign rif.open  = active ^ duck;
  assign rif.nsamp = active ? atk_n : rel_n;

  rvgt_ramp u_ramp (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .rif      (rif.ramp)
  );

  // Reverb geometry
  assign len_prod  = 20'(room_len(room)) * 20'(size_q[8:0]);
  assign rev_len   = (len_prod[19:6] == 14'h0) ? 13'h1 :
                     (len_prod[19] || len_prod[18:6] == 13'h0) ? 13'h1fff : len_prod[18:6];
  assign dlen_prod = 22'(rev_len) * 22'(dens[8:0]);
  assign rev_dlen  = (dlen_prod[21:20] != 2'h0) ? 13'h1fff :
                     (dlen_prod[19:7] == 13'h0) ? 13'h1 : dlen_prod[19:7];
  assign fb        = inf ? FB_INF : decay;

  // Small rooms use one reflection tap, larger ones add a density tap
  always_comb begin
    if (room == ROOM_BOOTH || room == ROOM_SMALL) begin
      rev_l = tap_l;
      rev_r = tap_r;
    end else begin
      rev_l = sat16((36'(tap_l) + 36'($signed(rev_rdata[31:16]))) >>> 1);
      rev_r = sat16((36'(tap_r) + 36'($signed(rev_rdata[15:0]))) >>> 1);
    end
    next_wet_l = sat16(mulsh(rev_l, 17'(mix), 8) + mulsh(dry_l, 17'(MIX_FULL_WET - mix), 8));
    next_wet_r = sat16(mulsh(rev_r, 17'(mix), 8) + mulsh(dry_r, 17'(MIX_FULL_WET - mix), 8));
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dry_l  <= 16'sh0;
      dry_r  <= 16'sh0;
      tap_l  <= 16'sh0;
      tap_r  <= 16'sh0;
      wet_l  <= 16'sh0;
      wet_r  <= 16'sh0;
      rev_wp <= 13'h0;
      dly_wp <= 11'h0;
    end else begin
      if (tick) begin
        dry_l <= in_left_i;
        dry_r <= in_right_i;
      end
      if (state == ST_TAP) begin
        tap_l <= $signed(rev_rdata[31:16]);
        tap_r <= $signed(rev_rdata[15:0]);
      end
      if (state == ST_MIX) begin
        wet_l  <= next_wet_l;
        wet_r  <= next_wet_r;
        rev_wp <= rev_wp + 13'h1;
      end
      if (state == ST_OUT) begin
        dly_wp <= dly_wp + 11'h1;
      end
    end
  end

  // Recirculating line: input plus scaled tap
  assign rev_we    = (state == ST_CLR) || (state == ST_MIX);
  assign rev_waddr = (state == ST_CLR) ? clr_cnt : rev_wp;
  assign rev_wdata = (state == ST_CLR) ? 32'h0 :
                     {sat16(36'(dry_l) + mulsh(tap_l, {1'b0, fb}, 15)),
                      sat16(36'(dry_r) + mulsh(tap_r, {1'b0, fb}, 15))};
  assign rev_raddr = (state == ST_TAP) ? rev_wp - rev_dlen : rev_wp - rev_len;

  rvgt_mem #(
    .AW (REV_AW),
    .DW (32)
  ) u_rev_mem (
    .clk_i   (clk_i),
    .we_i    (rev_we),
    .waddr_i (rev_waddr),
    .wdata_i (rev_wdata),
    .raddr_i (rev_raddr),
    .rdata_o (rev_rdata)
  );

  // Read follows the write so a zero delay returns the fresh word
  assign dly_we    = (state == ST_CLR) || (state == ST_MIX);
  assign dly_waddr = (state == ST_CLR) ? clr_cnt[10:0] : dly_wp;
  assign dly_wdata = (state == ST_CLR) ? 32'h0 : {next_wet_l, next_wet_r};
  assign dly_raddr = dly_wp - dly_n;

  rvgt_mem #(
    .AW (DLY_AW),
    .DW (32)
  ) u_dly_mem (
    .clk_i   (clk_i),
    .we_i    (dly_we),
    .waddr_i (dly_waddr),
    .wdata_i (dly_wdata),
    .raddr_i (dly_raddr),
    .rdata_o (dly_rdata)
  );

  assign gated_l = sat16(mulsh($signed(dly_rdata[31:16]), rif.gain, 16));
  assign gated_r = sat16(mulsh($signed(dly_rdata[15:0]), rif.gain, 16));

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_left_o  <= 16'sh0;
      out_right_o <= 16'sh0;
      out_valid_o <= 1'b0;
    end else begin
      out_valid_o <= (state == ST_OUT);
      if (state == ST_OUT) begin
        out_left_o  <= out_off ? 16'sh0 : sat16(mulsh(gated_l, {1'b0, ogain}, 12));
        out_right_o <= out_off ? 16'sh0 : sat16(mulsh(gated_r, {1'b0, ogain}, 12));
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_hold_reload: assert property (tick && next_above |=> hold_cnt == $past(hold_n))
    else $error("hold timer not reloaded above threshold");
  a_hold_count: assert property (tick && !next_above && hold_cnt != 18'h0
                                 |=> hold_cnt == $past(hold_cnt) - 18'h1)
    else $error("hold timer did not count down");
  a_sc_both: assert property (ctrl[1:0] == 2'h3 |-> sc_amp ==
                              17'(in_left_i[15] ? -17'(in_left_i) : 17'(in_left_i)) +
                              17'(in_right_i[15] ? -17'(in_right_i) : 17'(in_right_i)))
    else $error("summed side-chain amplitude wrong");
  a_thresh_cmp: assert property (tick |=> above == (env > {1'b0, $past(thresh)}))
    else $error("threshold compare mismatch");
  a_duck_target: assert property (rif.open == ((above || hold_cnt != 18'h0) != duck))
    else $error("gate target not inverted by ducking");
  a_ramp_up: assert property (rif.open && tick |=> rif.gain >= $past(rif.gain))
    else $error("opening ramp went down");
  a_ramp_down: assert property (!rif.open && tick |=> rif.gain <= $past(rif.gain))
    else $error("closing ramp went up");
  a_zero_delay: assert property (state == ST_OUT && $past(dly_n) == 11'h0
                                 |-> dly_rdata == {wet_l, wet_r})
    else $error("zero delay did not pass fresh sample");
  a_out_off: assert property (out_valid_o && $past(out_off)
                              |-> out_left_o == 16'sh0 && out_right_o == 16'sh0)
    else $error("output not silent when off");
  a_inf_fb: assert property (inf |-> fb == FB_INF)
    else $error("infinite decay feedback not full");
  a_out_latency: assert property (tick |-> ##5 out_valid_o ##1 !out_valid_o)
    else $error("output sample not five cycles after tick");
  a_reset_gate: assert property ($rose(state == ST_IDLE) && $past(state) == ST_CLR
                                 |-> hold_cnt == 18'h0)
    else $error("hold timer not clear after reset sweep");

  c_gate_rise: cover property (tick && next_above && !above);
  c_hold_expire: cover property (tick && !next_above && hold_cnt == 18'h1);
  c_duck_open: cover property (duck && rif.open && rif.gain == 17'h10000);
  c_inf_tail: cover property (inf && out_valid_o && out_left_o != 16'sh0);
endmodule : rvgt_top

// File: common/rvgt_pkg.sv
// Shared constants and types for the gated reverb block
package rvgt_pkg;
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned SAMPLE_DIV     = 500;
  localparam int unsigned SAMPLE_HZ      = CLK_HZ / SAMPLE_DIV;
  localparam int unsigned SAMP_PER_MS    = SAMPLE_HZ / 1000;
  localparam int unsigned SAMP_PER_TENTH = SAMPLE_HZ / 10000;
  localparam logic [15:0] HOLD_MAX_MS    = 16'h0bb8;
  localparam logic [15:0] REL_MAX_MS     = 16'h0bb8;
  localparam logic [15:0] ATK_MAX_TENTHS = 16'h08e8;
  localparam logic [15:0] DLY_MAX_TENTHS = 16'h00fa;
  localparam logic [15:0] MIX_FULL_WET   = 16'h0100;
  localparam logic [15:0] SCALE_MAX      = 16'h0100;
  localparam int unsigned REV_AW         = 13;
  localparam int unsigned DLY_AW         = 11;
  localparam int unsigned ENV_SHIFT      = 8;
  // Register word addresses
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_THRESH = 4'h1;
  localparam logic [3:0] REG_HOLD   = 4'h2;
  localparam logic [3:0] REG_ATK    = 4'h3;
  localparam logic [3:0] REG_REL    = 4'h4;
  localparam logic [3:0] REG_DELAY  = 4'h5;
  localparam logic [3:0] REG_OGAIN  = 4'h6;
  localparam logic [3:0] REG_MIX    = 4'h7;
  localparam logic [3:0] REG_SIZE   = 4'h8;
  localparam logic [3:0] REG_DENS   = 4'h9;
  localparam logic [3:0] REG_DECAY  = 4'ha;
  localparam logic [3:0] REG_STATUS = 4'hb;
  // Control field positions
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_DUCK     = 2;
  localparam int unsigned CTRL_INF      = 3;
  localparam int unsigned CTRL_OFF      = 4;
  localparam int unsigned CTRL_ROOM_LSB = 5;
  // Reset values
  localparam logic [15:0] CTRL_RST   = 16'h0063;
  localparam logic [15:0] THRESH_RST = 16'h0400;
  localparam logic [15:0] HOLD_RST   = 16'h0064;
  localparam logic [15:0] ATK_RST    = 16'h000a;
  localparam logic [15:0] REL_RST    = 16'h0064;
  localparam logic [15:0] DELAY_RST  = 16'h0000;
  localparam logic [15:0] OGAIN_RST  = 16'h1000;
  localparam logic [15:0] MIX_RST    = 16'h0080;
  localparam logic [15:0] SIZE_RST   = 16'h0040;
  localparam logic [15:0] DENS_RST   = 16'h0040;
  localparam logic [15:0] DECAY_RST  = 16'h6000;
  localparam logic [15:0] FB_INF     = 16'h7fff;
  localparam logic [24:0] GAIN_UNITY = 25'h1000000;

  typedef enum logic [1:0] {
    SC_NONE  = 2'h0,
    SC_LEFT  = 2'h1,
    SC_RIGHT = 2'h2,
    SC_BOTH  = 2'h3
  } rvgt_sc_type;

  typedef enum logic [2:0] {
    ROOM_BOOTH           = 3'h0,
    ROOM_SMALL           = 3'h1,
    ROOM_CHAMBER         = 3'h2,
    ROOM_HALL_PRESET_ONE = 3'h3,
    ROOM_LARGE           = 3'h4
  } rvgt_room_type;

  typedef enum logic [5:0] {
    ST_CLR  = 6'h01,
    ST_IDLE = 6'h02,
    ST_TAP  = 6'h04,
    ST_MIX  = 6'h08,
    ST_RDD  = 6'h10,
    ST_OUT  = 6'h20
  } rvgt_state_type;
endpackage : rvgt_pkg

// File: common/rvgt_ramp_if.sv
// Gate gain ramp control bundle
`timescale 1ns/10ps
interface rvgt_ramp_if;
  logic        tick;
  logic        open;
  logic [17:0] nsamp;
  logic [16:0] gain;
  modport ctl  (output tick, output open, output nsamp, input gain);
  modport ramp (input tick, input open, input nsamp, output gain);
endinterface : rvgt_ramp_if

// File: design/rvgt_mem.sv
// Simple dual-port sample memory with registered read
`timescale 1ns/10ps
module rvgt_mem #(
  parameter int unsigned AW = 11,
  parameter int unsigned DW = 32
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read before write on a shared address
  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule : rvgt_mem

// File: design/rvgt_ramp.sv
// Gate gain ramp with per-sample step from a serial divider
`timescale 1ns/10ps
module rvgt_ramp import rvgt_pkg::*; (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  rvgt_ramp_if.ramp rif
);
  logic [24:0] gain;
  logic [24:0] step;
  logic [24:0] quot;
  logic [25:0] rem;
  logic [17:0] div_n;
  logic [4:0]  bit_idx;
  logic        busy;
  logic [25:0] shifted;

  assign rif.gain = gain[24:8];
  assign shifted  = {rem[24:0], (bit_idx == 5'h18)};

  // Step = unity / samples, recomputed every sample
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy    <= 1'b0;
      bit_idx <= 5'h00;
      rem     <= 26'h0;
      quot    <= 25'h0;
      div_n   <= 18'h0;
      step    <= GAIN_UNITY;
    end else if (rif.tick) begin
      busy    <= (rif.nsamp != 18'h0);
      bit_idx <= 5'h18;
      rem     <= 26'h0;
      quot    <= 25'h0;
      div_n   <= rif.nsamp;
      if (rif.nsamp == 18'h0) begin
        step <= GAIN_UNITY;
      end
    end else if (busy) begin
      if (shifted >= {8'h0, div_n}) begin
        rem  <= shifted - {8'h0, div_n};
        quot <= {quot[23:0], 1'b1};
      end else begin
        rem  <= shifted;
        quot <= {quot[23:0], 1'b0};
      end
      if (bit_idx == 5'h00) begin
        busy <= 1'b0;
        step <= (shifted >= {8'h0, div_n}) ? {quot[23:0], 1'b1} : {quot[23:0], 1'b0};
      end else begin
        bit_idx <= bit_idx - 5'h01;
      end
    end
  end

  // Gain moves one step per sample, never overshooting
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gain <= 25'h0;
    end else if (rif.tick) begin
      if (rif.open) begin
        gain <= (GAIN_UNITY - gain > step) ? gain + step : GAIN_UNITY;
      end else begin
        gain <= (gain > step) ? gain - step : 25'h0;
      end
    end
  end
endmodule : rvgt_ramp

// File: dv/rvgt_src.sv
// Upstream stereo sample source model
`timescale 1ns/10ps
module rvgt_src (
  input  wire logic               clk_i,
  input  wire logic               sample_req_i,
  input  wire logic        [15:0] amp_left_i,
  input  wire logic        [15:0] amp_right_i,
  output logic signed      [15:0] left_o,
  output logic signed      [15:0] right_o
);
  logic neg;

  initial begin
    neg     = 1'b0;
    left_o  = '0;
    right_o = '0;
  end

  // Sign flips per taken sample so the detector must rectify
  always @(posedge clk_i) begin
    if (sample_req_i) begin
      neg     <= ~neg;
      left_o  <= neg ? $signed(amp_left_i) : -$signed(amp_left_i);
      right_o <= neg ? $signed(amp_right_i) : -$signed(amp_right_i);
    end
  end
endmodule : rvgt_src

// File: dv/testbench.sv
// Self-checking bench for the gated reverb block
`timescale 1ns/10ps
module testbench import rvgt_pkg::*;;
  logic               clk_i;
  logic               resetn_i;
  logic        [3:0]  addr_i;
  logic        [15:0] wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic        [15:0] rdata_o;
  logic signed [15:0] in_left_i;
  logic signed [15:0] in_right_i;
  logic               sample_req_o;
  logic signed [15:0] out_left_o;
  logic signed [15:0] out_right_o;
  logic               out_valid_o;
  logic        [15:0] amp_left;
  logic        [15:0] amp_right;
  logic        [15:0] rd_val;
  int                 mismatches;
  int                 total_checks;

  rvgt_top u_rvgt_top (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .in_left_i(in_left_i), .in_right_i(in_right_i), .sample_req_o(sample_req_o),
    .out_left_o(out_left_o), .out_right_o(out_right_o), .out_valid_o(out_valid_o));

  rvgt_src u_rvgt_src (.clk_i(clk_i), .sample_req_i(sample_req_o),
    .amp_left_i(amp_left), .amp_right_i(amp_right),
    .left_o(in_left_i), .right_o(in_right_i));

  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
    #1 check("rdata_idle", rdata_o, 16'h0000);
  endtask : reg_rd

  // Waits for n accepted samples, each with its output five cycles later
  task automatic wait_samples(input int n);
    int cnt;
    repeat (n) begin
      cnt = 0;
      do begin
        @(negedge clk_i);
        cnt++;
      end while (sample_req_o !== 1'b1 && cnt < 20000);
      if (cnt >= 20000) begin
        mismatches++;
        finish_test();
      end
      repeat (5) @(negedge clk_i);
      check("out_valid", {15'h0, out_valid_o}, 16'h0001);
    end
  endtask : wait_samples

  task automatic test_reg_map();
    logic [3:0]  adr [11] = '{REG_CTRL, REG_THRESH, REG_HOLD, REG_ATK, REG_REL, REG_DELAY,
                              REG_OGAIN, REG_MIX, REG_SIZE, REG_DENS, REG_DECAY};
    logic [15:0] rst [11] = '{CTRL_RST, THRESH_RST, HOLD_RST, ATK_RST, REL_RST, DELAY_RST,
                              OGAIN_RST, MIX_RST, SIZE_RST, DENS_RST, DECAY_RST};
    for (int i = 0; i < 11; i++) begin
      reg_rd(adr[i], rd_val);
      check("reset_value", rd_val, rst[i]);
    end
    reg_rd(4'hc, rd_val);
    check("unmapped", rd_val, 16'h0000);
    reg_wr(REG_HOLD, 16'hffff);
    reg_rd(REG_HOLD, rd_val);
    check("hold_clamp", rd_val, HOLD_MAX_MS);
    reg_wr(REG_MIX, 16'hffff);
    reg_rd(REG_MIX, rd_val);
    check("mix_clamp", rd_val, MIX_FULL_WET);
  endtask : test_reg_map

  task automatic test_side_chain();
    reg_wr(REG_MIX, 16'h0000);
    reg_wr(REG_HOLD, 16'h0001);
    reg_wr(REG_ATK, 16'h0000);
    reg_wr(REG_REL, 16'h0000);
    reg_wr(REG_CTRL, 16'h0061);
    amp_left  <= 16'h0300;
    amp_right <= 16'h0300;
    wait_samples(3);
    reg_rd(REG_STATUS, rd_val);
    check("left_below", {15'h0, rd_val[0]}, 16'h0000);
    reg_wr(REG_CTRL, 16'h0063);
    wait_samples(3);
    reg_rd(REG_STATUS, rd_val);
    check("sum_above", {13'h0, rd_val[2:0]}, 16'h0007);
    check("gain_open", {8'h0, rd_val[15:8]}, 16'h0080);
  endtask : test_side_chain

  task automatic test_duck_and_off();
    reg_wr(REG_CTRL, 16'h0067);
    wait_samples(3);
    reg_rd(REG_STATUS, rd_val);
    check("duck_closed", {8'h0, rd_val[15:8]}, 16'h0000);
    reg_wr(REG_CTRL, 16'h0073);
    wait_samples(3);
    check("off_left", out_left_o, 16'h0000);
    check("off_right", out_right_o, 16'h0000);
  endtask : test_duck_and_off

  task automatic test_hold_release();
    reg_wr(REG_CTRL, 16'h0063);
    reg_wr(REG_THRESH, 16'h7fff);
    wait_samples(3);
    reg_rd(REG_STATUS, rd_val);
    check("hold_running", {13'h0, rd_val[2:0]}, 16'h0006);
    check("hold_gain", {8'h0, rd_val[15:8]}, 16'h0080);
    check("open_left", out_left_o[15] ? 16'(-out_left_o) : out_left_o, 16'h0300);
    wait_samples(55);
    reg_rd(REG_STATUS, rd_val);
    check("hold_done", {13'h0, rd_val[2:0]}, 16'h0000);
    check("released", {8'h0, rd_val[15:8]}, 16'h0000);
    check("closed_left", out_left_o, 16'h0000);
  endtask : test_hold_release

  // Five-sample delay keeps the old level visible after the input drops
  task automatic test_delay();
    reg_wr(REG_CTRL, 16'h0067);
    reg_wr(REG_DELAY, 16'h0001);
    wait_samples(4);
    @(posedge clk_i);
    amp_left <= 16'h0100;
    wait_samples(3);
    check("dly_old", out_left_o[15] ? 16'(-out_left_o) : out_left_o, 16'h0300);
    wait_samples(4);
    check("dly_new", out_left_o[15] ? 16'(-out_left_o) : out_left_o, 16'h0100);
  endtask : test_delay

  initial begin
    mismatches   = 0;
    total_checks = 0;
    resetn_i     = 1'b0;
    addr_i       = '0;
    wdata_i      = '0;
    wr_i         = 1'b0;
    rd_i         = 1'b0;
    amp_left     = '0;
    amp_right    = '0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    test_reg_map();
    test_side_chain();
    test_duck_and_off();
    test_hold_release();
    test_delay();
    finish_test();
  end

  // Runs well past the roughly fifty thousand cycles the tests need
  initial begin
    #(80000 * 40);
    mismatches++;
    finish_test();
  end
endmodule : testbench
